// File: src/sqf_sequencer.sv
// SPI command interpreter with diagnostic pipeline and arm/fire sequencing
`timescale 1ns/1ns
// Behaviour
// [RQ1] Short diagnostic result returns on next exchange
// [RQ2] Resistance command starts measurement, result next exchange
// [RQ3] Continuity flags captured, cleared after transfer
// [RQ4] Loop-to-loop test result on following exchange
// [RQ5] Arm/fire works same in any configuration
// [RQ6] Host turns remote low side on first
// [RQ7] Continuity reports only local low-side flags
// [RQ8] Cross-coupled loop sense command returns result
// [RQ9] Firing needs arm then fire, permit high
// [RQ10] Permit one gates 1A/1B, two gates 2A/2B
// [RQ11] Arm codes: pair one, pair two, all
// [RQ12] Arm and fire bytes echoed next exchange
// [RQ13] Fire low nibble sets per-driver on/off
// [RQ14] Fire nibble mismatch ignored, sequence restarts
// [RQ15] Command takes effect at chip select rise
// [RQ16] NOP/undefined clears diagnostics, shifts register out
// [RQ17] Fire without preceding arm changes nothing
module sqf_sequencer
	import sqf_pkg::*;
(
	input wire logic CLK,
	input wire logic RST_N,
	input wire logic CE,
	input wire logic SCLK,
	input wire logic CS_N,
	input wire logic MOSI,
	output logic MISO,
	output logic MISO_OE,
	input wire logic FIRE_PERMIT_PAIR_ONE,
	input wire logic FIRE_PERMIT_PAIR_TWO,
	input wire logic [3:0] LOW_SIDE_CONTINUITY_FLAG,
	input wire logic [7:0] SHORT_RESULT,
	input wire logic [7:0] MEAS_RESULT,
	input wire logic [7:0] LOOP_RESULT,
	output logic DIAG_START,
	output logic [7:0] DIAG_CMD,
	output logic [3:0] SQUIB_HIGH_PIN,
	output logic [3:0] SQUIB_LOW_PIN
);
	logic [2:0] sclk_sync_reg, cs_sync_reg;
	logic [1:0] mosi_sync_reg, perm1_sync_reg, perm2_sync_reg;
	logic sclk_rise, sclk_fall, cs_fall, cs_rise, exec;
	logic [3:0] bit_cnt_reg, permit_mask, arm_mask_reg, drv_reg, cont_reg;
	logic [3:0] arm_nib_reg;
	logic [7:0] rx_reg, tx_reg, cmd;
	sqf_mode_t mode_reg;

	// Arm code to channel mask
	function automatic logic [3:0] arm_mask(input logic [7:0] c);
		case (c)
			SQF_CMD_ARM_ONE: arm_mask = SQF_MASK_PAIR_ONE;
			SQF_CMD_ARM_TWO: arm_mask = SQF_MASK_PAIR_TWO;
			SQF_CMD_ARM_ALL: arm_mask = SQF_MASK_PAIR_ONE | SQF_MASK_PAIR_TWO;
			default: arm_mask = SQF_NIB_RST;
		endcase
	endfunction

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			sclk_sync_reg <= 3'h0;
			cs_sync_reg <= 3'h7;
			mosi_sync_reg <= 2'h0;
			perm1_sync_reg <= 2'h0;
			perm2_sync_reg <= 2'h0;
		end else if (CE) begin
			sclk_sync_reg <= {sclk_sync_reg[1:0], SCLK};
			cs_sync_reg <= {cs_sync_reg[1:0], CS_N};
			mosi_sync_reg <= {mosi_sync_reg[0], MOSI};
			perm1_sync_reg <= {perm1_sync_reg[0], FIRE_PERMIT_PAIR_ONE};
			perm2_sync_reg <= {perm2_sync_reg[0], FIRE_PERMIT_PAIR_TWO};
		end
	end

	// Edges seen on synchronised levels
	assign sclk_rise = CE && sclk_sync_reg[1] && !sclk_sync_reg[2] && !cs_sync_reg[1];
	assign sclk_fall = CE && !sclk_sync_reg[1] && sclk_sync_reg[2] && !cs_sync_reg[1];
	assign cs_fall = CE && !cs_sync_reg[1] && cs_sync_reg[2];
	assign cs_rise = CE && cs_sync_reg[1] && !cs_sync_reg[2];
	// Only whole 8-bit words act, and only at deselect
	assign exec = cs_rise && (bit_cnt_reg == SQF_BIT_CNT_WORD); // RQ15
	assign cmd = rx_reg;
	assign permit_mask = {{2{perm2_sync_reg[1]}}, {2{perm1_sync_reg[1]}}};

	// Receive shift, MSB first, on SCLK rise; count saturates so long words are refused
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rx_reg <= SQF_BYTE_RST;
			bit_cnt_reg <= SQF_NIB_RST;
		end else if (cs_fall) begin
			bit_cnt_reg <= SQF_NIB_RST;
		end else if (sclk_rise) begin
			rx_reg <= {rx_reg[6:0], mosi_sync_reg[1]};
			if (bit_cnt_reg != SQF_BIT_CNT_MAX) begin
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
			end
		end
	end

	// Transmit: answer chosen at select, shifted on SCLK fall
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			tx_reg <= SQF_BYTE_RST;
		end else if (cs_fall) begin
			case (mode_reg)
				SQF_M_ECHO: tx_reg <= rx_reg; // RQ12
				SQF_M_SHORT: tx_reg <= SHORT_RESULT; // RQ1
				SQF_M_MEAS: tx_reg <= MEAS_RESULT; // RQ2
				SQF_M_CONT: tx_reg <= {4'h0, cont_reg}; // RQ3 RQ7
				SQF_M_LOOP: tx_reg <= LOOP_RESULT; // RQ4 RQ8
				default: tx_reg <= rx_reg; // RQ16
			endcase
		end else if (sclk_fall) begin
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end
	assign MISO = tx_reg[7];
	assign MISO_OE = !cs_sync_reg[1];

	// Diagnostic mode and continuity latch; a new capture wins over the clear
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			mode_reg <= SQF_M_NONE;
			cont_reg <= SQF_NIB_RST;
		end else if (cs_rise) begin
			if (mode_reg == SQF_M_CONT) begin
				cont_reg <= SQF_NIB_RST; // RQ3
			end
			if (exec) begin
				if (cmd[7:4] == SQF_NIB_FIRE || arm_mask(cmd) != SQF_NIB_RST) begin
					mode_reg <= SQF_M_ECHO; // RQ12
				end else if (cmd == SQF_CMD_SHORT) begin
					mode_reg <= SQF_M_SHORT; // RQ1
				end else if (cmd[7:2] == SQF_FAM_MEAS) begin
					mode_reg <= SQF_M_MEAS; // RQ2
				end else if (cmd == SQF_CMD_CONT) begin
					mode_reg <= SQF_M_CONT;
					cont_reg <= LOW_SIDE_CONTINUITY_FLAG; // RQ3 RQ7
				end else if (cmd[7:2] == SQF_FAM_LOOP || cmd == SQF_CMD_LOOP_SENSE) begin
					mode_reg <= SQF_M_LOOP; // RQ4 RQ8
				end else begin
					mode_reg <= SQF_M_NONE; // RQ16
				end
			end
		end
	end

	// Start pulse to the analog side for every diagnostic command
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			DIAG_START <= 1'b0;
			DIAG_CMD <= SQF_BYTE_RST;
		end else if (CE) begin
			DIAG_START <= exec && (cmd == SQF_CMD_SHORT || cmd == SQF_CMD_CONT || cmd[7:2] == SQF_FAM_MEAS
				|| cmd[7:2] == SQF_FAM_LOOP || cmd == SQF_CMD_LOOP_SENSE); // RQ2 RQ4
			if (exec) begin
				DIAG_CMD <= cmd;
			end
		end
	end

	// Arm then fire; any other word, or a short word, breaks the pair
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			arm_mask_reg <= SQF_NIB_RST;
			arm_nib_reg <= SQF_NIB_RST;
			drv_reg <= SQF_NIB_RST;
		end else if (cs_rise) begin
			arm_mask_reg <= SQF_NIB_RST; // RQ17
			if (exec && arm_mask(cmd) != SQF_NIB_RST) begin
				arm_mask_reg <= arm_mask(cmd) & permit_mask; // RQ10 RQ11
				arm_nib_reg <= cmd[7:4];
			end else if (exec && cmd[7:4] == SQF_NIB_FIRE && cmd[7:4] == ~arm_nib_reg) begin
				// Drivers outside the armed pair keep their state
				drv_reg <= (drv_reg & ~arm_mask_reg) | (cmd[3:0] & arm_mask_reg); // RQ9 RQ13 RQ14 RQ5
			end
		end
	end

	// Same drive to both sides so one IC or a cross-coupled pair fire alike
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			SQUIB_HIGH_PIN <= SQF_NIB_RST;
			SQUIB_LOW_PIN <= SQF_NIB_RST;
		end else if (CE) begin
			SQUIB_HIGH_PIN <= drv_reg & permit_mask; // RQ9 RQ10 RQ5
			SQUIB_LOW_PIN <= drv_reg & permit_mask; // RQ5
		end
	end

	arm_then_fire_a: assert property (@(posedge CLK) disable iff (!RST_N) // RQ17
		$changed(drv_reg) |-> $past(arm_mask_reg) != 4'h0 && $past(exec))
		else $error("driver state changed without a preceding arm");
	fire_nibble_a: assert property (@(posedge CLK) disable iff (!RST_N) // RQ14
		$changed(drv_reg) |-> $past(cmd[7:4]) == SQF_NIB_FIRE)
		else $error("driver state changed by a non-fire byte");
	take_effect_a: assert property (@(posedge CLK) disable iff (!RST_N) // RQ15
		!cs_rise |=> $stable(drv_reg) && $stable(mode_reg))
		else $error("command acted before chip select rose");
	permit_gate_a: assert property (@(posedge CLK) disable iff (!RST_N) // RQ10
		CE && !perm2_sync_reg[1] |=> SQUIB_HIGH_PIN[3:2] == 2'h0)
		else $error("pair two driven without its permit");
	permit_one_a: assert property (@(posedge CLK) disable iff (!RST_N) // RQ10
		CE && !perm1_sync_reg[1] |=> SQUIB_HIGH_PIN[1:0] == 2'h0)
		else $error("pair one driven without its permit");
	echo_arm_a: assert property (@(posedge CLK) disable iff (!RST_N) // RQ12
		cs_fall && mode_reg == SQF_M_ECHO |=> tx_reg == $past(rx_reg))
		else $error("arm or fire byte not echoed");
	short_pipe_a: assert property (@(posedge CLK) disable iff (!RST_N) // RQ1
		exec && cmd == SQF_CMD_SHORT |=> mode_reg == SQF_M_SHORT && DIAG_START)
		else $error("short diagnostic not pipelined");
	cont_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // RQ3
		cs_rise && mode_reg == SQF_M_CONT && !(exec && cmd == SQF_CMD_CONT) |=> cont_reg == 4'h0)
		else $error("continuity latch not cleared after transfer");
	nop_clear_a: assert property (@(posedge CLK) disable iff (!RST_N) // RQ16
		exec && cmd == SQF_CMD_NOP |=> mode_reg == SQF_M_NONE && !DIAG_START)
		else $error("NOP left a diagnostic mode active");
	arm_mask_a: assert property (@(posedge CLK) disable iff (!RST_N) // RQ11
		exec && cmd == SQF_CMD_ARM_ONE |=> (arm_mask_reg & SQF_MASK_PAIR_TWO) == 4'h0)
		else $error("pair-one arm armed pair two");
endmodule

// File: src/sqf_pkg.sv
// Constants for the squib arm/fire SPI command sequencer
package sqf_pkg;
	localparam int SQF_WORD_BITS = 8;
	localparam logic [3:0] SQF_BIT_CNT_MAX = 4'hF;
	localparam logic [3:0] SQF_BIT_CNT_WORD = 4'h8;
	// Command codes and families
	localparam logic [7:0] SQF_CMD_NOP = 8'h00;
	localparam logic [7:0] SQF_CMD_SHORT = 8'hC1;
	localparam logic [7:0] SQF_CMD_CONT = 8'hC2;
	localparam logic [7:0] SQF_CMD_ARM_ONE = 8'hA0;
	localparam logic [7:0] SQF_CMD_ARM_TWO = 8'hA1;
	localparam logic [7:0] SQF_CMD_ARM_ALL = 8'hA2;
	localparam logic [7:0] SQF_CMD_LOOP_SENSE = 8'hE8;
	localparam logic [5:0] SQF_FAM_MEAS = 6'h34;
	localparam logic [5:0] SQF_FAM_LOOP = 6'h38;
	localparam logic [3:0] SQF_NIB_FIRE = 4'h5;
	// Channel masks: bit 0 1A, bit 1 1B, bit 2 2A, bit 3 2B
	localparam logic [3:0] SQF_MASK_PAIR_ONE = 4'h3;
	localparam logic [3:0] SQF_MASK_PAIR_TWO = 4'hC;
	// Reset values
	localparam logic [7:0] SQF_BYTE_RST = 8'h00;
	localparam logic [3:0] SQF_NIB_RST = 4'h0;
	typedef enum logic [2:0] {SQF_M_NONE, SQF_M_ECHO, SQF_M_SHORT, SQF_M_MEAS, SQF_M_CONT, SQF_M_LOOP} sqf_mode_t;
endpackage

// File: verification/sqf_spi_host.sv
// SPI master model standing in for the host microcontroller
`timescale 1ns/1ns
module sqf_host_model (
	input wire logic clk,
	input wire logic miso,
	input wire logic miso_oe,
	output logic sclk,
	output logic cs_n,
	output logic mosi
);
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		mosi = 1'b0;
	end
	// One 8-bit exchange, mode 0, MSB first, 80 ns link clock
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		@(posedge clk) cs_n <= 1'b0;
		repeat (6) @(posedge clk);
		for (int i = 7; i >= 0; i--) begin
			mosi <= tx[i];
			repeat (4) @(posedge clk);
			// Sample away from the clock edge to avoid a race
			@(negedge clk) rx[i] = miso_oe ? miso : 1'bx;
			@(posedge clk) sclk <= 1'b1;
			repeat (5) @(posedge clk);
			sclk <= 1'b0;
		end
		repeat (6) @(posedge clk);
		cs_n <= 1'b1;
		// Released data line must not keep the last bit
		mosi <= ~tx[0];
		repeat (8) @(posedge clk);
	endtask
endmodule

// File: verification/test_squib_spi_arm_fire_sequencer.sv
// Self-checking bench for the squib arm/fire SPI sequencer
`timescale 1ns/1ns
module test_squib_spi_arm_fire_sequencer;
	import sqf_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic miso, miso_oe, sclk, cs_n, mosi, diag_start;
	logic perm_one = 1'b1;
	logic perm_two = 1'b1;
	logic ce = 1'b1;
	logic [7:0] diag_cnt = 8'h00;
	logic [7:0] diag_cmd;
	logic [3:0] hi_pin, lo_pin;
	logic [7:0] rx;
	int errors = 0;
	int cmp_count = 0;
	// 125 MHz system clock
	always #4 clk = ~clk;
	sqf_host_model u_host (.clk(clk), .miso(miso), .miso_oe(miso_oe), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));
	sqf_sequencer u_dut (.CLK(clk), .RST_N(rst_n), .CE(ce), .SCLK(sclk), .CS_N(cs_n), .MOSI(mosi),
		.MISO(miso), .MISO_OE(miso_oe), .FIRE_PERMIT_PAIR_ONE(perm_one), .FIRE_PERMIT_PAIR_TWO(perm_two),
		.LOW_SIDE_CONTINUITY_FLAG(4'hA), .SHORT_RESULT(8'h3C), .MEAS_RESULT(8'h5A), .LOOP_RESULT(8'hC3),
		.DIAG_START(diag_start), .DIAG_CMD(diag_cmd), .SQUIB_HIGH_PIN(hi_pin), .SQUIB_LOW_PIN(lo_pin));
	// Tally start pulses; each stands one cycle so every edge is looked at
	always @(posedge clk) begin
		if (diag_start) begin
			diag_cnt <= diag_cnt + 8'h01;
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		cmp_count++;
		if (got !== exp) begin
			$display("ERROR %0t: got %h expected %h", $time, got, exp);
			errors++;
		end
	endtask
	// Exchange a command and compare the answer to the previous one
	task automatic x(input logic [7:0] tx, input logic [7:0] exp);
		u_host.xfer(tx, rx);
		chk(rx, exp);
	endtask
	// Driver outputs, both sides must agree
	task automatic drv(input logic [3:0] exp);
		chk({4'h0, hi_pin}, {4'h0, exp});
		chk({4'h0, lo_pin}, {4'h0, exp});
	endtask
	task automatic end_sim;
		$display("Comparisons %0d, errors %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Watchdog against a hung exchange
	initial begin
		repeat (20000) @(posedge clk);
		errors++;
		end_sim();
	end
	initial begin
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		drv(4'h0);
		x(SQF_CMD_SHORT, 8'h00);
		x(8'hD0, 8'h3C);
		chk(diag_cmd, 8'hD0);
		x(SQF_CMD_CONT, 8'h5A);
		x(8'hE0, 8'h0A);
		x(SQF_CMD_NOP, 8'hC3);
		x(8'h17, 8'h00);
		x(SQF_CMD_LOOP_SENSE, 8'h17);
		x(8'hA0, 8'hC3);
		x(8'h53, 8'hA0);
		// High and low sides of pair one come on together from one fire byte
		drv(4'h3);
		x(SQF_CMD_ARM_TWO, 8'h53);
		x(8'h5C, 8'hA1);
		drv(4'hF);
		// Permit pin one gates pair one on its own
		@(posedge clk) perm_one <= 1'b0;
		repeat (6) @(posedge clk);
		drv(4'hC);
		@(posedge clk) perm_one <= 1'b1;
		repeat (6) @(posedge clk);
		drv(4'hF);
		// Frozen clock enable holds the pins although permit two drops
		@(posedge clk);
		ce <= 1'b0;
		perm_two <= 1'b0;
		repeat (6) @(posedge clk);
		drv(4'hF);
		ce <= 1'b1;
		repeat (6) @(posedge clk);
		drv(4'h3);
		// Arming pair two without its permit arms nothing
		x(SQF_CMD_ARM_TWO, 8'h5C);
		x(8'h50, 8'hA1);
		@(posedge clk) perm_two <= 1'b1;
		repeat (6) @(posedge clk);
		drv(4'hF);
		x(SQF_CMD_ARM_ALL, 8'h50);
		x(8'h60, 8'hA2);
		drv(4'hF);
		x(8'h50, 8'h60);
		drv(4'hF);
		x(SQF_CMD_ARM_ALL, 8'h50);
		x(8'h50, 8'hA2);
		drv(4'h0);
		x(SQF_CMD_ARM_ALL, 8'h50);
		x(8'h5F, 8'hA2);
		drv(4'hF);
		// Reset in mid-run drops every driver and the diagnostic mode
		@(posedge clk) rst_n <= 1'b0;
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		repeat (4) @(posedge clk);
		drv(4'h0);
		x(SQF_CMD_NOP, 8'h00);
		chk(diag_cnt, 8'h05);
		end_sim();
	end
endmodule
